// ### rtl/tff_defs.svh
// Register offsets, field positions and reset values of the texel formatter
`ifndef TFF_DEFS_SVH
`define TFF_DEFS_SVH
// ------------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------------
`define TFF_FMT_OFS      12'h000
`define TFF_MODE_OFS     12'h004
`define TFF_BASE_OFS     12'h008
`define TFF_LRBASE_OFS   12'h00c
`define TFF_INTERP_A_OFS 12'h010
`define TFF_INTERP_C_OFS 12'h014
`define TFF_INTERP_E_OFS 12'h018
`define TFF_STATUS_OFS   12'h01c
`define TFF_PAL_OFS      12'h040
// ------------------------------------------------------------------------
// Format control fields
// ------------------------------------------------------------------------
`define TFF_F_ORDER      0
`define TFF_F_ALT        1
`define TFF_F_SEQ        2
`define TFF_F_COMP_LO    3
`define TFF_F_ROUTE_LO   5
`define TFF_F_MIRROR     7
`define TFF_F_INVERT     8
`define TFF_F_BSWAP      9
// ------------------------------------------------------------------------
// Read mode fields
// ------------------------------------------------------------------------
`define TFF_M_WIDTH_LO   1
`define TFF_M_HEIGHT_LO  5
`define TFF_M_DEPTH_LO   9
`define TFF_M_MAG        14
`define TFF_M_MIN_LO     15
`define TFF_M_MAPTYPE    22
`define TFF_M_ASSIST     23
// ------------------------------------------------------------------------
// Reset values and the fill for missing alpha
// ------------------------------------------------------------------------
`define TFF_FMT_RST      10'h000
`define TFF_MODE_RST     24'h000000
`define TFF_ALPHA_FULL   8'hff
`endif

// ### rtl/tff_pkg.sv
// Types shared by the texel formatter
package tff_pkg;
  typedef enum logic [1:0] {
    TFF_ROUTE_TEXEL,
    TFF_ROUTE_COLOR,
    TFF_ROUTE_MASK,
    TFF_ROUTE_RSVD
  } tff_route_e;
  typedef logic [31:0] tff_word_t;
endpackage

// ### rtl/tff_texel_format.sv
// Texel formatter with mipmap-assist state and APB register access
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "tff_defs.svh"
// How it works
// - Assist bit selects min filter, else ignored
// - Interpolants are 9-bit 1.8 unsigned
// - Low-res exponents one less, clamped zero
// - Map parameters shared, only pointers differ
// - Up to four neighbour texels per level
// - Only low 32 memory bits used
// - Depths 1 to 32 bits become 32-bit
// - Order bit picks texel end within word
// - Small texels index sixteen-entry palette
// - Eight-bit texels expand by component count
// - Sixteen-bit texels of three or four components follow alternative-format bit
// - Luminance replicated, missing alpha is 255
// - Undefined combination uses earlier entry
// - Component count selects one to four
// - Byte swap, mirror, invert in order
// - Byte swap reverses four bytes
// - Mirror reverses all 32 bits
// - Invert complements every bit
// - Routing: texel, color or span mask
module tff_texel_format
  import tff_pkg::*;
#(
  parameter int MEM_W = 32                   // Memory word width
) (
  input  wire logic             mclk_in,      // Core clock
  input  wire logic             rst_b_in,     // Async reset, active low
  input  wire logic             psel_in,      // APB select
  input  wire logic             penable_in,   // APB access phase
  input  wire logic             pwrite_in,    // APB direction
  input  wire logic [11:0]      paddr_in,     // APB byte address
  input  wire logic [31:0]      pwdata_in,    // APB write data
  output logic                  pready_out,   // APB ready
  output logic      [31:0]      prdata_out,   // APB read data
  output logic                  pslverr_out,  // APB error
  input  wire logic             mem_valid_in, // Memory word valid
  input  wire logic [MEM_W-1:0] mem_data_in,  // Memory word
  input  wire logic [4:0]       texel_u_in,   // Texel position in word
  input  wire logic             span_valid_in,// Rasterizer span valid
  input  wire logic [31:0]      span_data_in, // Rasterizer span data
  output logic                  texel_valid_out, // To color stage
  output logic      [31:0]      texel_out,
  output logic                  color_valid_out, // Finished color
  output logic      [31:0]      color_out,
  output logic                  span_valid_out,  // Masked span
  output logic      [31:0]      span_out,
  output logic      [2:0]       filter_out,   // Active filter operation
  output logic      [3:0]       lr_width_out, // Low-res width exponent
  output logic      [3:0]       lr_height_out // Low-res height exponent
);
  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic [9:0]  texel_format_control_reg;    // Format control
  logic [23:0] fetch_mode_register_reg;     // Read mode
  logic [28:0] map_base_pointer_reg;        // Primary map
  logic [28:0] low_res_map_pointer_reg;     // Low-res map
  logic [8:0]  interpolant_slot_a_reg;      // 1.8 coefficients
  logic [8:0]  interpolant_slot_c_reg;
  logic [8:0]  interpolant_slot_e_reg;
  tff_word_t   index_palette_reg [16];      // Palette entries
  logic [31:0] mask_hold_reg;               // Held span mask
  logic        mask_full_reg;               // Mask waiting for span

  // Decoded control fields
  logic       order_big;
  logic       alt_fmt;
  logic       seq_rgb;
  logic [1:0] comp_cnt;
  tff_route_e route;
  logic [2:0] depth;
  assign order_big = texel_format_control_reg[`TFF_F_ORDER];
  assign alt_fmt   = texel_format_control_reg[`TFF_F_ALT];
  assign seq_rgb   = texel_format_control_reg[`TFF_F_SEQ];
  assign comp_cnt  = texel_format_control_reg[`TFF_F_COMP_LO +: 2];
  assign route     = tff_route_e'(texel_format_control_reg[`TFF_F_ROUTE_LO +: 2]);
  assign depth     = fetch_mode_register_reg[`TFF_M_DEPTH_LO +: 3];

  // ----------------------------------------------------------------------
  // APB slave: zero wait, error on unmapped address
  // ----------------------------------------------------------------------
  logic acc;
  logic pal_hit;
  logic mapped;
  assign acc     = psel_in & penable_in;
  assign pal_hit = (paddr_in[11:6] == 6'(`TFF_PAL_OFS >> 6)) &&
                   (paddr_in[1:0] == 2'h0);
  always_comb begin
    case (paddr_in)
      `TFF_FMT_OFS, `TFF_MODE_OFS, `TFF_BASE_OFS, `TFF_LRBASE_OFS,
      `TFF_INTERP_A_OFS, `TFF_INTERP_C_OFS, `TFF_INTERP_E_OFS,
      `TFF_STATUS_OFS: mapped = 1'b1;
      default:         mapped = pal_hit;
    endcase
  end

  // Registers written by software; palette has no reset (plain RAM)
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      texel_format_control_reg <= `TFF_FMT_RST;
      fetch_mode_register_reg  <= `TFF_MODE_RST;
      map_base_pointer_reg     <= 29'h0;
      low_res_map_pointer_reg  <= 29'h0;
      interpolant_slot_a_reg   <= 9'h000;
      interpolant_slot_c_reg   <= 9'h000;
      interpolant_slot_e_reg   <= 9'h000;
    end else if (acc && pwrite_in) begin
      case (paddr_in)
        `TFF_FMT_OFS:      texel_format_control_reg <= pwdata_in[9:0];
        `TFF_MODE_OFS:     fetch_mode_register_reg  <= pwdata_in[23:0];
        // Both pointers sit beside one shared mode word
        `TFF_BASE_OFS:     map_base_pointer_reg     <= pwdata_in[28:0];
        `TFF_LRBASE_OFS:   low_res_map_pointer_reg  <= pwdata_in[28:0];
        // Upper bits beyond 1.8 are dropped
        `TFF_INTERP_A_OFS: interpolant_slot_a_reg   <= pwdata_in[8:0];
        `TFF_INTERP_C_OFS: interpolant_slot_c_reg   <= pwdata_in[8:0];
        `TFF_INTERP_E_OFS: interpolant_slot_e_reg   <= pwdata_in[8:0];
        default: ;
      endcase
    end
  end

  // Palette written one word per entry
  always_ff @(posedge mclk_in) begin
    if (acc && pwrite_in && pal_hit)
      index_palette_reg[paddr_in[5:2]] <= pwdata_in;
  end

  // Read data and answer, registered
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pready_out  <= 1'b0;
      prdata_out  <= 32'h0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= psel_in & ~penable_in;   // Ready in access phase
      pslverr_out <= psel_in & ~penable_in & ~mapped;
      prdata_out  <= 32'h0;
      if (psel_in && !penable_in && !pwrite_in) begin
        case (paddr_in)
          `TFF_FMT_OFS:      prdata_out <= {22'h0, texel_format_control_reg};
          `TFF_MODE_OFS:     prdata_out <= {8'h0, fetch_mode_register_reg};
          `TFF_BASE_OFS:     prdata_out <= {3'h0, map_base_pointer_reg};
          `TFF_LRBASE_OFS:   prdata_out <= {3'h0, low_res_map_pointer_reg};
          `TFF_INTERP_A_OFS: prdata_out <= {23'h0, interpolant_slot_a_reg};
          `TFF_INTERP_C_OFS: prdata_out <= {23'h0, interpolant_slot_c_reg};
          `TFF_INTERP_E_OFS: prdata_out <= {23'h0, interpolant_slot_e_reg};
          `TFF_STATUS_OFS:   prdata_out <= {31'h0, mask_full_reg};
          default:
            if (pal_hit)
              prdata_out <= index_palette_reg[paddr_in[5:2]];
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Mipmap assist: filter choice and low-res exponents
  // ----------------------------------------------------------------------
  logic [3:0] w_exp;
  logic [3:0] h_exp;
  assign w_exp = fetch_mode_register_reg[`TFF_M_WIDTH_LO +: 4];
  assign h_exp = fetch_mode_register_reg[`TFF_M_HEIGHT_LO +: 4];
  // Filter seen by the address stage; fetch count follows from it
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      filter_out    <= 3'h0;
      lr_width_out  <= 4'h0;
      lr_height_out <= 4'h0;
    end else begin
      if (fetch_mode_register_reg[`TFF_M_ASSIST])
        filter_out <= fetch_mode_register_reg[`TFF_M_MIN_LO +: 3];
      else
        filter_out <= {2'h0, fetch_mode_register_reg[`TFF_M_MAG]};
      lr_width_out  <= (w_exp == 4'h0) ? 4'h0 : w_exp - 4'h1;
      lr_height_out <= (h_exp == 4'h0) ? 4'h0 : h_exp - 4'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Texel extraction from the low 32 memory bits
  // ----------------------------------------------------------------------
  tff_word_t  word;
  logic [4:0] idx;
  logic [4:0] pos;
  logic [4:0] size_m1;
  tff_word_t  raw;
  assign word = mem_data_in[31:0];
  always_comb begin
    size_m1 = 5'((6'h1 << depth) - 6'h1);
    idx     = 5'(texel_u_in << depth);            // Bit offset of texel
    // Little order counts from the top, big order from bit 0
    pos     = order_big ? idx : 5'(5'h1f - idx - size_m1);
    raw     = (word >> pos) & ((depth >= 3'h5) ? 32'hffffffff :
              32'((33'h1 << (6'h1 << depth)) - 33'h1));
  end

  // ----------------------------------------------------------------------
  // Expansion into the internal word (R at byte 0, A at byte 3)
  // ----------------------------------------------------------------------
  function automatic logic [7:0] rep3(input logic [2:0] v);
    rep3 = {v, v, v[2:1]};
  endfunction
  function automatic logic [7:0] rep5(input logic [4:0] v);
    rep5 = {v, v[4:2]};
  endfunction
  tff_word_t  expd;
  logic [7:0] cr, cg, cb, ca, c0, c2;
  logic [1:0] eff_cnt;
  logic [2:0] edep;                                 // Depth used to expand
  always_comb begin
    c0 = 8'h0;
    c2 = 8'h0;
    ca = `TFF_ALPHA_FULL;
    eff_cnt = comp_cnt;
    // Wide texels with too few components fall back to earlier entries,
    // surplus high bits are simply not looked at
    edep = depth;
    if (depth == 3'h5 && comp_cnt != 2'h3)
      edep = 3'h4;
    if (edep == 3'h4 && comp_cnt == 2'h0)
      edep = 3'h3;
    case (eff_cnt)
      2'h0: begin
        c0 = raw[7:0];
        c2 = raw[7:0];
      end
      2'h1: begin
        if (edep == 3'h4) begin
          c0 = raw[7:0];
          ca = raw[15:8];
        end else begin
          c0 = {raw[3:0], raw[3:0]};
          ca = {raw[7:4], raw[7:4]};
        end
        c2 = c0;
      end
      2'h2: begin
        if (edep == 3'h4 && !alt_fmt) begin
          c0 = rep5(raw[4:0]);
          c2 = rep5(raw[15:11]);
        end else if (edep == 3'h4) begin
          c0 = rep5(raw[4:0]);
          c2 = rep5(raw[14:10]);
        end else begin
          c0 = rep3(raw[2:0]);
          c2 = rep3(raw[7:5]);
        end
      end
      default: begin
        if (edep == 3'h5) begin
          c0 = raw[7:0];
          c2 = raw[23:16];
          ca = raw[31:24];
        end else if (edep == 3'h4 && !alt_fmt) begin
          c0 = {raw[3:0], raw[3:0]};
          c2 = {raw[11:8], raw[11:8]};
          ca = {raw[15:12], raw[15:12]};
        end else if (edep == 3'h4) begin
          c0 = rep5(raw[4:0]);
          c2 = rep5(raw[14:10]);
          ca = {8{raw[15]}};
        end else begin
          c0 = {raw[1:0], raw[1:0], raw[1:0], raw[1:0]};
          c2 = {raw[6:5], raw[6:5], raw[6:5], raw[6:5]};
          ca = {8{raw[7]}};
        end
      end
    endcase
    // Green field per format
    case (eff_cnt)
      2'h0:    cg = c0;
      2'h1:    cg = c0;
      // Green of 3-3-2 sits one bit higher in BGR order
      2'h2:    cg = (edep == 3'h4) ?
                    (alt_fmt ? rep5(raw[9:5]) : {raw[10:5], raw[10:9]}) :
                    (seq_rgb ? rep3(raw[4:2]) : rep3(raw[5:3]));
      default: cg = (edep == 3'h5) ? raw[15:8] :
                    (edep == 3'h4) ?
                    (alt_fmt ? rep5(raw[9:5]) : {raw[7:4], raw[7:4]}) :
                    rep3(raw[4:2]);
    endcase
    // Low field is red in BGR order, blue in RGB order
    cr = seq_rgb ? c2 : c0;
    cb = seq_rgb ? c0 : c2;
    // Blue of 3-3-2 is only two bits wide
    if (eff_cnt == 2'h2 && edep == 3'h3)
      cb = seq_rgb ? {raw[1:0], raw[1:0], raw[1:0], raw[1:0]}
                   : {raw[7:6], raw[7:6], raw[7:6], raw[7:6]};
    if (depth <= 3'h2)
      expd = index_palette_reg[raw[3:0]];
    else
      expd = {ca, cb, cg, cr};
  end

  // ----------------------------------------------------------------------
  // Byte swap, then mirror, then invert
  // ----------------------------------------------------------------------
  tff_word_t sw, mir, post;
  assign sw = texel_format_control_reg[`TFF_F_BSWAP] ?
              {expd[7:0], expd[15:8], expd[23:16], expd[31:24]} : expd;
  genvar gb;
  for (gb = 0; gb < 32; gb++) begin : g_mirror
    assign mir[gb] = texel_format_control_reg[`TFF_F_MIRROR] ?
                     sw[31-gb] : sw[gb];
  end
  assign post = texel_format_control_reg[`TFF_F_INVERT] ? ~mir : mir;

  // ----------------------------------------------------------------------
  // Output routing
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      texel_valid_out <= 1'b0;
      texel_out       <= 32'h0;
      color_valid_out <= 1'b0;
      color_out       <= 32'h0;
    end else begin
      // Reserved value behaves as texel so nothing stalls
      texel_valid_out <= mem_valid_in &&
        (route == TFF_ROUTE_TEXEL || route == TFF_ROUTE_RSVD);
      color_valid_out <= mem_valid_in && route == TFF_ROUTE_COLOR;
      if (mem_valid_in) begin
        texel_out <= post;
        color_out <= post;
      end
    end
  end

  // Mask held until the next span; a fresh word replaces an unused one
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mask_hold_reg  <= 32'h0;
      mask_full_reg  <= 1'b0;
      span_valid_out <= 1'b0;
      span_out       <= 32'h0;
    end else begin
      span_valid_out <= span_valid_in && mask_full_reg;
      if (span_valid_in && mask_full_reg)
        span_out <= span_data_in & mask_hold_reg;
      if (mem_valid_in && route == TFF_ROUTE_MASK) begin
        mask_hold_reg <= post;
        mask_full_reg <= 1'b1;                      // Set wins over use
      end else if (span_valid_in)
        mask_full_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  route_texel_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    mem_valid_in && route != TFF_ROUTE_COLOR && route != TFF_ROUTE_MASK
    |=> texel_valid_out && texel_out == $past(post))
    else $error("texel route missed");
  route_color_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    mem_valid_in && route == TFF_ROUTE_COLOR |=> color_valid_out && !texel_valid_out)
    else $error("color route missed");
  sequence mask_load_s;
    mem_valid_in && route == TFF_ROUTE_MASK && !span_valid_in;
  endsequence
  mask_and_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    mask_load_s ##1 (span_valid_in && !mem_valid_in)
    |=> span_valid_out && span_out == ($past(span_data_in) & $past(post, 2)))
    else $error("span mask wrong");
  lr_clamp_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    $stable(fetch_mode_register_reg) |=>
    (w_exp == 4'h0 && lr_width_out == 4'h0) ||
    (5'(lr_width_out) + 5'h1 == 5'(w_exp)))
    else $error("low-res width wrong");
  assist_min_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    fetch_mode_register_reg[`TFF_M_ASSIST] && $stable(fetch_mode_register_reg)
    |=> filter_out == fetch_mode_register_reg[`TFF_M_MIN_LO +: 3])
    else $error("assist filter wrong");
  swap_order_a: assert property (@(posedge mclk_in)
    texel_format_control_reg[`TFF_F_BSWAP] && !texel_format_control_reg[`TFF_F_MIRROR]
    && !texel_format_control_reg[`TFF_F_INVERT] |-> post[7:0] == expd[31:24])
    else $error("byte swap wrong");
  mirror_bit_a: assert property (@(posedge mclk_in)
    texel_format_control_reg[`TFF_F_MIRROR] && !texel_format_control_reg[`TFF_F_INVERT]
    |-> post[0] == sw[31])
    else $error("mirror wrong");
  alpha_full_a: assert property (@(posedge mclk_in)
    depth == 3'h3 && comp_cnt == 2'h2 |-> expd[31:24] == 8'hff)
    else $error("alpha not full");
endmodule // tff_texel_format
`default_nettype wire

// ### verif/tff_far_side.sv
// Far-side model: local memory words and rasterizer spans
`timescale 1ns/100ps
`default_nettype none
module tff_far_side #(
  parameter int MEM_W = 40                // Memory word width
) (
  input  wire logic             clk_in,   // Core clock
  input  wire logic             rst_b_in, // Async reset, active low
  input  wire logic             send_in,  // Deliver one word
  input  wire logic [31:0]      word_in,  // Texture word
  input  wire logic [4:0]       u_in,     // Texel position
  input  wire logic             ssend_in, // Deliver one span
  input  wire logic [31:0]      sword_in, // Span data
  output logic                  mvalid_out,
  output logic      [MEM_W-1:0] mdata_out,
  output logic      [4:0]       u_out,
  output logic                  svalid_out,
  output logic      [31:0]      sdata_out
);
  // ----------------------------------------
  // Delivery, one cycle per word
  // ----------------------------------------
  // Idle lines flip so stale data never passes for valid
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mvalid_out <= 1'b0;
      mdata_out  <= '0;
      u_out      <= '0;
      svalid_out <= 1'b0;
      sdata_out  <= '0;
    end else begin
      mvalid_out <= send_in;
      svalid_out <= ssend_in;
      // Upper bits set: reader must drop them
      mdata_out  <= send_in ? {{(MEM_W-32){1'b1}}, word_in} : ~mdata_out;
      u_out      <= send_in ? u_in : ~u_out;
      sdata_out  <= ssend_in ? sword_in : ~sdata_out;
    end
  end
endmodule // tff_far_side
`default_nettype wire

// ### verif/tff_texel_format_tb.sv
// Self-checking bench for the texel formatter
`timescale 1ns/100ps
`default_nettype none
module tff_texel_format_tb;
  // ----------------------------------------
  // Signals and result queues
  // ----------------------------------------
  logic        mclk, rst_b, psel, pen, pwr, send, ssend;
  logic [11:0] paddr;
  logic [31:0] pwdata, word, sword, pd, td, cd, sdat, w, s, f;
  logic [4:0]  u, tu;
  logic [39:0] mdat;          // Wider than a texel word on purpose
  logic        pr, pe, mv, sv, tv, cv, so;
  logic [2:0]  filt;
  logic [3:0]  lw, lh;
  logic [7:0]  b;
  logic [33:0] out_q[$];      // {channel, data} of texel, color and span outputs
  logic [33:0] bus_q[$];      // {error, read data}
  int          miscompares, check_count;

  tff_texel_format #(.MEM_W(40)) tff_texel_format_i (
    .mclk_in(mclk), .rst_b_in(rst_b), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
    .pwdata_in(pwdata), .pready_out(pr), .prdata_out(pd),
    .pslverr_out(pe), .mem_valid_in(mv), .mem_data_in(mdat),
    .texel_u_in(tu), .span_valid_in(sv), .span_data_in(s),
    .texel_valid_out(tv), .texel_out(td), .color_valid_out(cv),
    .color_out(cd), .span_valid_out(so), .span_out(sdat),
    .filter_out(filt), .lr_width_out(lw), .lr_height_out(lh));

  tff_far_side #(.MEM_W(40)) tff_far_side_i (
    .clk_in(mclk), .rst_b_in(rst_b), .send_in(send), .word_in(word),
    .u_in(u), .ssend_in(ssend), .sword_in(sword), .mvalid_out(mv),
    .mdata_out(mdat), .u_out(tu), .svalid_out(sv), .sdata_out(s));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [33:0] e, input logic [33:0] g);
    check_count++;
    if (e !== g) begin
      miscompares++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // One compare task per kind of result
  task automatic chk_bus(input logic [33:0] e, input logic [33:0] g);
    chk(e, g);
  endtask

  task automatic chk_pix(input logic [33:0] e, input logic [33:0] g);
    chk(e, g);
  endtask

  task automatic chk_ctl(input logic [33:0] e, input logic [33:0] g);
    chk(e, g);
  endtask

  task automatic report_and_stop;
    if (miscompares == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // One APB cycle; waits on pready, no fixed latency assumed
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1; pen <= 1'b0; pwr <= wr; paddr <= a; pwdata <= d;
    @(posedge mclk);
    pen <= 1'b1;
    // Only the watchdog ends a wait that never gets an answer
    do
      @(posedge mclk);
    while (pr !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    bus_q.push_back({1'b0, e});
    apb(1'b0, a, 32'h0);
  endtask

  // Word request held up across back-to-back calls
  task automatic tx(input logic [31:0] d, input logic [4:0] uu);
    @(posedge mclk);
    send <= 1'b1; word <= d; u <= uu;
  endtask

  task automatic idle;
    @(posedge mclk);
    send <= 1'b0; ssend <= 1'b0;
  endtask

  task automatic sp(input logic [31:0] d);
    @(posedge mclk);
    ssend <= 1'b1; sword <= d;
    idle;
  endtask

  // Byte swap, then mirror, then invert
  function automatic logic [31:0] post(input logic [31:0] x,
                                       input logic [2:0] c);
    if (c[2]) x = {x[7:0], x[15:8], x[23:16], x[31:24]};
    if (c[0]) x = {<<{x}};
    if (c[1]) x = ~x;
    return x;
  endfunction

  // ----------------------------------------
  // Clock, watchdog and output monitor
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    report_and_stop;
  end

  // An output with no note pending compares against unknown
  always @(posedge mclk) begin
    if (psel && pen && pr === 1'b1 && !pwr)
      chk_bus(bus_q.size() ? bus_q.pop_front() : 'x, {1'b0, pe, pd});
    if (tv === 1'b1)
      chk_pix(out_q.size() ? out_q.pop_front() : 'x, {2'd0, td});
    if (cv === 1'b1)
      chk_pix(out_q.size() ? out_q.pop_front() : 'x, {2'd1, cd});
    if (so === 1'b1)
      chk_pix(out_q.size() ? out_q.pop_front() : 'x, {2'd2, sdat});
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {psel, pen, pwr, send, ssend} = '0;
    paddr = '0; pwdata = '0; word = '0; sword = '0; u = '0; rst_b = 1'b0;
    void'($urandom(26603));
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    rd(12'h000, 33'h0);
    rd(12'h004, 33'h0);
    bus_q.push_back({2'b01, 32'h0});
    apb(1'b0, 12'h020, 32'h0);
    apb(1'b1, 12'h004, 32'h828060);
    apb(1'b1, 12'h014, 32'h3ff);
    rd(12'h014, 33'h1ff);
    repeat (2) @(posedge mclk);
    chk_ctl({23'h0, filt, lw, lh}, {23'h0, 3'd5, 4'd0, 4'd2});
    apb(1'b1, 12'h004, 32'h2c060);
    repeat (2) @(posedge mclk);
    chk_ctl({23'h0, filt, lw, lh}, {23'h0, 3'd1, 4'd0, 4'd2});
    apb(1'b1, 12'h004, 32'ha00);
    for (int c = 0; c < 8; c++) begin
      f = 32'h18 | (c << 7) | (c[0] ? 32'h20 : c[1] ? 32'h60 : 32'h0);
      apb(1'b1, 12'h000, f);
      repeat (2) begin
        w = $urandom;
        out_q.push_back({1'b0, c[0], post(w, c[2:0])});
        tx(w, 5'd0);
      end
      idle;
    end
    apb(1'b1, 12'h004, 32'h600);
    for (int o = 0; o < 2; o++) begin
      apb(1'b1, 12'h000, o);
      w = $urandom;
      b = o ? w[15:8] : w[23:16];
      out_q.push_back({2'd0, 8'hff, b, b, b});
      tx(w, 5'd1);
      idle;
    end
    // Three components, BGR: 3-3-2 with blue on top
    apb(1'b1, 12'h000, 32'h10);
    w = $urandom;
    b = w[23:16];
    out_q.push_back({2'd0, 8'hff, {4{b[7:6]}}, b[5:3], b[5:3], b[5:4],
                     b[2:0], b[2:0], b[2:1]});
    tx(w, 5'd1);
    idle;
    apb(1'b1, 12'h004, 32'h400);
    apb(1'b1, 12'h000, 32'h0);
    for (int n = 0; n < 16; n += 5) begin
      f = $urandom;
      apb(1'b1, 12'h040 + 12'(4 * n), f);
      w = $urandom;
      w[3:0] = 4'(n);
      out_q.push_back({2'd0, f});
      tx(w, 5'd7);
      idle;
    end
    sp(32'hffffffff);
    apb(1'b1, 12'h004, 32'ha00);
    apb(1'b1, 12'h000, 32'h58);
    w = $urandom;
    f = $urandom;
    out_q.push_back({2'd2, w & f});
    tx(w, 5'd0);
    // Span right behind the word; a second span then finds no mask
    @(posedge mclk);
    send <= 1'b0;
    ssend <= 1'b1;
    sword <= f;
    idle;
    sp(f);
    repeat (6) @(posedge mclk);
    if (out_q.size() != 0 || bus_q.size() != 0) miscompares++;
    report_and_stop;
  end
endmodule // tff_texel_format_tb
`default_nettype wire
